//--- src/sfl_pkg.sv
/*
  Shared constants, field layouts and types of the serial port status flag block.
  Assumes a 125 MHz core clock and a word-aligned APB register map.
*/
package sfl_pkg;

  // APB address width and register indices; byte address is four times the index
  localparam int ADDR_W = 12;
  localparam logic [7:0] IDX_TXBUF = 8'h9A;
  localparam logic [7:0] IDX_RXBUF = 8'h9B;
  localparam logic [7:0] IDX_CONFIG = 8'hE8;
  localparam logic [7:0] IDX_STATUS = 8'hEA;
  localparam logic [7:0] IDX_IRQ_STAT = 8'hF0;
  localparam logic [7:0] IDX_IRQ_CLR = 8'hF1;
  localparam logic [7:0] IDX_IRQ_EN = 8'hF2;
  localparam logic [1:0] WORD_LSBS = 2'h0;

  // Reset values
  localparam logic [7:0] CONFIG_RESET = 8'h01;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [3:0] SYNC_RESET = 4'h8;

  // Status bit positions used by write-zero clears
  localparam int POS_MULTIMASTER_ERROR_FLAG = 6;
  localparam int POS_TX_UNF = 2;
  localparam int POS_TX_REQ = 1;
  localparam int POS_TX_FULL = 0;

  // Interrupt status bits
  localparam int IRQ_W = 5;
  localparam int IRQ_RX_NEW = 0;
  localparam int IRQ_TX_EMPTY = 1;
  localparam int IRQ_RX_OVF = 2;
  localparam int IRQ_TX_UNF = 3;
  localparam int IRQ_MULTIMASTER_ERROR_FLAG = 4;

  // Byte framing
  localparam logic [3:0] BIT_COUNT_FULL = 4'h8;
  localparam logic [3:0] BIT_COUNT_LAST = 4'h7;

  // Master serial clock half period
  localparam int CLK_PERIOD_NS = 8;
  localparam int SCLK_HALF_NS = 40;
  localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic ss_in_en;
    logic port_en;
    logic ovw_en;
    logic master_en;
    logic [2:0] spare;
    logic transfer_interrupt_mode;
  } sfl_cfg_t;

  typedef struct packed {
    logic busy;
    logic multimaster_error_flag;
    logic rx_ovf;
    logic rx_req;
    logic rx_full;
    logic tx_unf;
    logic tx_req;
    logic tx_full;
  } sfl_stat_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_FINISH = 3'b100
  } sfl_state_t;

  function automatic logic sfl_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
    return addr == {idx, WORD_LSBS};
  endfunction : sfl_hit

endpackage : sfl_pkg

//--- src/sfl_sync3.sv
/*
  Three-stage synchroniser for pin inputs.
  Assumes inputs are asynchronous to pclk; output follows once stages two and three agree.
*/
`timescale 1ns/1ps
module sfl_sync3 #(
  parameter int W = 4,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] ff1;
  logic [W-1:0] ff2;
  logic [W-1:0] ff3;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ff1 <= RST;
      ff2 <= RST;
      ff3 <= RST;
    end else begin
      ff1 <= d;
      ff2 <= ff1;
      ff3 <= ff2;
    end
  end

  // A bit moves only when the last two stages agree, which filters one-cycle glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= RST;
    end else begin
      q <= (ff2 & ~(ff2 ^ ff3)) | (q & (ff2 ^ ff3));
    end
  end

endmodule : sfl_sync3

//--- src/sfl_shift.sv
/*
  Byte shift register, MSB first, with sample and shift strobes.
  Assumes the caller sequences load, sample and shift; done pulses on the eighth sample.
*/
`timescale 1ns/1ps
module sfl_shift (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic load,
  input wire logic [7:0] load_data,
  input wire logic sample,
  input wire logic shift,
  input wire logic sin,
  // Results
  output logic sout,
  output logic [3:0] count,
  output logic [7:0] rx_byte,
  output logic done
);
  import sfl_pkg::*;

  logic [7:0] sr;
  logic in_bit;

  assign sout = sr[7];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sr <= 8'h00;
      in_bit <= 1'b0;
      count <= 4'h0;
      rx_byte <= 8'h00;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        sr <= load_data;
        count <= 4'h0;
      end else if (sample) begin
        in_bit <= sin;
        if (count != BIT_COUNT_FULL) begin
          count <= count + 4'h1;
        end
        if (count == BIT_COUNT_LAST) begin
          rx_byte <= {sr[6:0], sin};
          done <= 1'b1;
        end
      end else if (shift) begin
        sr <= {sr[6:0], in_bit};
      end
    end
  end

endmodule : sfl_shift

//--- src/sfl_spi_flags.sv
/*
  Serial port core with status and interrupt flags, reached over APB.
  Assumes pins are asynchronous to pclk and that the far party keeps mode 0 framing.
*/
`timescale 1ns/1ps
module sfl_spi_flags #(
  parameter int HALF_CYCLES = sfl_pkg::SCLK_HALF_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [sfl_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // Serial clock pin
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe,
  // Master out pin
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  // Master in pin
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  // Slave select pin, active low
  input wire logic ss_n_i,
  output logic ss_n_o,
  output logic ss_n_oe
);
  import sfl_pkg::*;

  sfl_cfg_t cfg;
  sfl_stat_t stat;
  sfl_state_t mst_state;
  logic [7:0] tx_buf;
  logic [7:0] rx_buf;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_en;
  logic [IRQ_W-1:0] irq_ev;
  logic [7:0] div_cnt;
  logic tick;
  logic [3:0] pins_s;
  logic sclk_s, mosi_s, miso_s, ss_s;
  logic sclk_d, ss_d;
  logic sh_load, sh_sample, sh_shift, sh_sin, sh_sout, byte_done;
  logic [7:0] sh_data;
  logic [7:0] rx_byte;
  logic [3:0] sh_cnt;
  logic byte_ovf;
  logic [31:0] rd_mux;

  // Pin synchronisers
  sfl_sync3 #(.W(4), .RST(SYNC_RESET)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({ss_n_i, miso_i, mosi_i, sclk_i}),
    .q(pins_s)
  );
  assign sclk_s = pins_s[0];
  assign mosi_s = pins_s[1];
  assign miso_s = pins_s[2];
  assign ss_s = pins_s[3];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_d <= 1'b0;
      ss_d <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
      ss_d <= ss_s;
    end
  end

  // APB decode
  logic setup, access, wr_ev, tx_wr, stat_wr, rx_read_clr, mapped;
  assign setup = psel & ~penable;
  assign access = psel & penable & pready;
  assign wr_ev = access & pwrite;
  assign tx_wr = wr_ev & sfl_hit(paddr, IDX_TXBUF);
  assign stat_wr = wr_ev & sfl_hit(paddr, IDX_STATUS);
  // Read side effect is taken with the read data so the cleared byte is the one returned
  assign rx_read_clr = setup & ~pwrite & sfl_hit(paddr, IDX_RXBUF);
  assign mapped = sfl_hit(paddr, IDX_TXBUF) | sfl_hit(paddr, IDX_RXBUF) | sfl_hit(paddr, IDX_CONFIG)
                | sfl_hit(paddr, IDX_STATUS) | sfl_hit(paddr, IDX_IRQ_STAT) | sfl_hit(paddr, IDX_IRQ_CLR)
                | sfl_hit(paddr, IDX_IRQ_EN);

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sfl_hit(paddr, IDX_TXBUF)) rd_mux[7:0] = tx_buf;
    if (sfl_hit(paddr, IDX_RXBUF)) rd_mux[7:0] = rx_buf;
    if (sfl_hit(paddr, IDX_CONFIG)) rd_mux[7:0] = cfg;
    if (sfl_hit(paddr, IDX_STATUS)) rd_mux[7:0] = stat;
    if (sfl_hit(paddr, IDX_IRQ_STAT)) rd_mux[IRQ_W-1:0] = irq_stat;
    if (sfl_hit(paddr, IDX_IRQ_EN)) rd_mux[IRQ_W-1:0] = irq_en;
  end

  // One wait-free access phase per transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup & ~pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // Configuration and interrupt enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= CONFIG_RESET;
      irq_en <= '0;
    end else begin
      if (wr_ev & sfl_hit(paddr, IDX_CONFIG)) cfg <= pwdata[7:0];
      if (wr_ev & sfl_hit(paddr, IDX_IRQ_EN)) irq_en <= pwdata[IRQ_W-1:0];
    end
  end

  // Transfer control
  logic slave_act, ss_fall, sclk_rise, sclk_fall, slv_in;
  logic mst_end, slv_end, byte_end, mst_start, mst_go_on, tx_take, mm_hit;
  assign slave_act = cfg.port_en & ~cfg.master_en;
  assign slv_in = slave_act & ~ss_s;
  assign ss_fall = ss_d & ~ss_s;
  assign sclk_rise = ~sclk_d & sclk_s;
  assign sclk_fall = sclk_d & ~sclk_s;
  assign mst_end = (mst_state == ST_SHIFT) & tick & sclk_o & (sh_cnt == BIT_COUNT_FULL);
  assign slv_end = slv_in & sclk_fall & (sh_cnt == BIT_COUNT_FULL);
  assign byte_end = mst_end | slv_end;
  assign mst_start = (mst_state == ST_IDLE) & cfg.port_en & cfg.master_en & stat.tx_full;
  // Continue only with fresh data and, in mode zero, with the last byte taken
  assign mst_go_on = mst_end & stat.tx_full & ~(~cfg.transfer_interrupt_mode & byte_ovf);
  assign tx_take = mst_start | mst_go_on | (slave_act & (ss_fall | slv_end) & stat.tx_full);
  assign mm_hit = (mst_state != ST_IDLE) & cfg.ss_in_en & ~ss_s;
  assign sh_load = mst_start | mst_go_on | (slave_act & (ss_fall | slv_end));
  // A slave with nothing queued sends zeros rather than repeating stale data
  assign sh_data = stat.tx_full ? tx_buf : 8'h00;
  assign sh_sample = ((mst_state == ST_SHIFT) & tick & ~sclk_o) | (slv_in & sclk_rise);
  assign sh_shift = (((mst_state == ST_SHIFT) & tick & sclk_o) | (slv_in & sclk_fall))
                  & (sh_cnt != BIT_COUNT_FULL);
  assign sh_sin = cfg.master_en ? miso_s : mosi_s;

  sfl_shift u_shift (
    .pclk(pclk),
    .presetn(presetn),
    .load(sh_load),
    .load_data(sh_data),
    .sample(sh_sample),
    .shift(sh_shift),
    .sin(sh_sin),
    .sout(sh_sout),
    .count(sh_cnt),
    .rx_byte(rx_byte),
    .done(byte_done)
  );

  // Half-period divider, held clear while idle so every byte starts on a full half period
  assign tick = (mst_state != ST_IDLE) & (div_cnt == 8'(HALF_CYCLES - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 8'h00;
    end else if (mst_state == ST_IDLE || tick) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // Master sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mst_state <= ST_IDLE;
      sclk_o <= 1'b0;
      ss_n_o <= 1'b1;
    end else begin
      case (mst_state)
        ST_IDLE: begin
          sclk_o <= 1'b0;
          if (mst_start) begin
            mst_state <= ST_SHIFT;
            ss_n_o <= 1'b0;
          end
        end
        ST_SHIFT: begin
          if (mm_hit) begin
            mst_state <= ST_IDLE;
            sclk_o <= 1'b0;
            ss_n_o <= 1'b1;
          end else if (tick) begin
            sclk_o <= ~sclk_o;
            if (mst_end & ~mst_go_on) mst_state <= ST_FINISH;
          end
        end
        ST_FINISH: begin
          // A rival master cuts the closing half period short as well
          if (tick | mm_hit) begin
            ss_n_o <= 1'b1;
            mst_state <= ST_IDLE;
          end
        end
        default: begin
          mst_state <= ST_IDLE;
          ss_n_o <= 1'b1;
        end
      endcase
    end
  end

  // Pin drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_oe <= 1'b0;
      mosi_o <= 1'b0;
      mosi_oe <= 1'b0;
      miso_o <= 1'b0;
      miso_oe <= 1'b0;
      ss_n_oe <= 1'b0;
    end else begin
      sclk_oe <= cfg.port_en & cfg.master_en;
      mosi_oe <= cfg.port_en & cfg.master_en;
      mosi_o <= sh_sout;
      miso_o <= sh_sout;
      miso_oe <= slv_in;
      ss_n_oe <= cfg.port_en & cfg.master_en & ~cfg.ss_in_en;
    end
  end

  // Overflow of the byte just received, kept for the end-of-byte decision
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_ovf <= 1'b0;
    end else if (byte_done) begin
      byte_ovf <= stat.rx_full & ~rx_read_clr;
    end
  end

  // Buffers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buf <= 8'h00;
      rx_buf <= 8'h00;
    end else begin
      if (tx_wr) tx_buf <= pwdata[7:0];
      if (byte_done & (~stat.rx_full | rx_read_clr | cfg.ovw_en)) rx_buf <= rx_byte;
    end
  end

  // Status flags: clears first, hardware sets after so a set in the same cycle wins, except tx_req, which a buffer write clears last
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat <= STATUS_RESET;
    end else begin
      stat.busy <= (mst_state != ST_IDLE) | slv_in;
      if (stat_wr) begin
        if (!pwdata[POS_MULTIMASTER_ERROR_FLAG]) stat.multimaster_error_flag <= 1'b0;
        if (!pwdata[POS_TX_UNF]) stat.tx_unf <= 1'b0;
        if (!pwdata[POS_TX_REQ]) stat.tx_req <= 1'b0;
        if (!pwdata[POS_TX_FULL]) stat.tx_full <= 1'b0;
      end
      if (rx_read_clr) begin
        stat.rx_ovf <= 1'b0;
        stat.rx_req <= 1'b0;
        stat.rx_full <= 1'b0;
      end
      if (tx_take) begin
        stat.tx_full <= 1'b0;
        stat.tx_req <= 1'b1;
      end
      if (tx_wr) begin
        stat.tx_full <= 1'b1;
        stat.tx_req <= 1'b0;
      end
      if (mm_hit) stat.multimaster_error_flag <= 1'b1;
      if (byte_end & ~stat.tx_full) stat.tx_unf <= 1'b1;
      if (byte_done) begin
        if (stat.rx_full & ~rx_read_clr) begin
          stat.rx_ovf <= 1'b1;
        end else begin
          stat.rx_req <= 1'b1;
          stat.rx_full <= 1'b1;
        end
      end
    end
  end

  // Interrupt: sticky events, write one to clear, enable gates the single output
  always_comb begin
    irq_ev = '0;
    irq_ev[IRQ_RX_NEW] = byte_done & (~stat.rx_full | rx_read_clr);
    irq_ev[IRQ_TX_EMPTY] = tx_take;
    irq_ev[IRQ_RX_OVF] = byte_done & stat.rx_full & ~rx_read_clr;
    irq_ev[IRQ_TX_UNF] = byte_end & ~stat.tx_full;
    irq_ev[IRQ_MULTIMASTER_ERROR_FLAG] = mm_hit;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~((wr_ev & sfl_hit(paddr, IDX_IRQ_CLR)) ? pwdata[IRQ_W-1:0] : '0)) | irq_ev;
      irq <= |(irq_stat & irq_en);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_BUSY: assert property ((mst_state == ST_SHIFT) |=> stat.busy)
    else $error("busy low during master shift");
  AST_MULTIMASTER_ERROR_FLAG: assert property (mm_hit |=> stat.multimaster_error_flag && mst_state == ST_IDLE ##1 ss_n_o)
    else $error("multimaster error not raised");
  AST_OVF: assert property ((byte_done && stat.rx_full && !rx_read_clr) |=> stat.rx_ovf)
    else $error("overflow not flagged");
  AST_DISCARD: assert property ((byte_done && stat.rx_full && !rx_read_clr && !cfg.ovw_en)
    |=> $stable(rx_buf))
    else $error("receive buffer changed without overwrite");
  AST_RX_NEW: assert property (byte_done |=> stat.rx_req && stat.rx_full && rx_buf == $past(rx_byte)
    || stat.rx_ovf)
    else $error("new byte not flagged");
  AST_RX_CLR: assert property ((rx_read_clr && !byte_done) |=> !stat.rx_req && !stat.rx_full && !stat.rx_ovf)
    else $error("receive read did not clear");
  AST_HALT: assert property ((mst_end && !cfg.transfer_interrupt_mode && byte_ovf) |=> mst_state == ST_FINISH ##[1:40] ss_n_o)
    else $error("mode zero halt missing");
  AST_STOP: assert property ((mst_end && !stat.tx_full) |=> stat.tx_unf && mst_state == ST_FINISH
    ##[1:40] ss_n_o)
    else $error("transfer did not stop on empty buffer");
  AST_TAKE: assert property ((tx_take && !tx_wr) |=> stat.tx_req && !stat.tx_full)
    else $error("transmit request not set");
  AST_TXWR: assert property ((tx_wr && !stat_wr) |=> !stat.tx_req && stat.tx_full)
    else $error("buffer write did not clear request");
  AST_ZERO: assert property ((stat_wr && !pwdata[POS_TX_FULL] && !tx_wr && !tx_take && !byte_done)
    |=> !stat.tx_full && $stable(stat.rx_req))
    else $error("written zero clear wrong");

endmodule : sfl_spi_flags

//--- verification/sfl_spi_peer.sv
/*
  Behavioural SPI slave at the far side of the port: mode 0, MSB first.
  Assumes the port is master and owns the serial clock and the select line.
*/
`timescale 1ns/1ps
module sfl_spi_peer (
  // Link pins
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic mosi,
  output logic miso,
  // Bench control
  input wire logic [7:0] reply,
  input wire logic slow,
  // Observed traffic
  output logic [7:0] got,
  output int unsigned nbytes
);
  logic [7:0] sh_in;
  logic [7:0] sh_out;
  int bits;

  initial begin
    miso = 1'b0;
    got = 8'h00;
    nbytes = 0;
    bits = 0;
    sh_in = 8'h00;
    sh_out = 8'h00;
  end

  // Each byte answers reply plus the bytes seen so far, so bytes can be told apart
  always @(negedge ss_n) begin
    sh_out = reply + 8'(nbytes);
    bits = 0;
    // The slow delay stays under one core clock: the port samples through a pin synchroniser
    miso <= #(slow ? 6 : 1) sh_out[7];
  end

  // A released line shows the inverse of its last value, never a stale bit
  always @(posedge ss_n) begin
    miso <= ~miso;
  end

  always @(posedge sclk) begin
    if (!ss_n) begin
      sh_in = {sh_in[6:0], mosi};
      bits++;
      if (bits == 8) begin
        got = sh_in;
        nbytes++;
        bits = 0;
      end
    end
  end

  always @(negedge sclk) begin
    if (!ss_n) begin
      sh_out = (bits == 0) ? reply + 8'(nbytes) : {sh_out[6:0], 1'b0};
      miso <= #(slow ? 6 : 1) sh_out[7];
    end
  end
endmodule : sfl_spi_peer

//--- verification/testbench.sv
/*
  Self-checking bench of the serial port flag block: APB tasks, scenarios, verdict.
  Assumes APB accesses end when pready is seen, with no fixed wait count, and the peer model on the link pins.
*/
`timescale 1ns/1ps
module testbench;
  import sfl_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err, slow, drv_ss_n, log_rise;
  logic sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_n_o, ss_n_oe, peer_miso;
  logic sclk_w, mosi_w, miso_w, ss_w;
  logic drv_sclk, drv_mosi;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [7:0] reply, peer_got, b0, b1;
  int unsigned peer_n, n0, at_rise, errors, total_checks;

  // Wire levels from the port's enables; the bench and the peer drive whenever the port does not
  assign sclk_w = sclk_oe ? sclk_o : drv_sclk;
  assign mosi_w = mosi_oe ? mosi_o : drv_mosi;
  assign miso_w = miso_oe ? miso_o : peer_miso;
  assign ss_w = ss_n_oe ? ss_n_o : drv_ss_n;

  sfl_spi_flags #(.HALF_CYCLES(5)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .sclk_i(sclk_w), .sclk_o(sclk_o), .sclk_oe(sclk_oe),
    .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o),
    .miso_oe(miso_oe), .ss_n_i(ss_w), .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe));

  sfl_spi_peer peer (.sclk(sclk_w), .ss_n(ss_w), .mosi(mosi_w), .miso(peer_miso), .reply(reply),
    .slow(slow), .got(peer_got), .nbytes(peer_n));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  always @(posedge ss_w) begin
    if (log_rise) begin
      at_rise = peer_n;
      log_rise <= 1'b0;
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Overwrite keeps the later reply, otherwise the earlier one stays
  function automatic logic [31:0] exp_rx(input logic ovw, input logic [7:0] base, input int unsigned n);
    return {24'h000000, ovw ? base + 8'(n + 1) : base + 8'(n)};
  endfunction : exp_rx

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, idx, WORD_LSBS};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle count is assumed; only the watchdog ends a wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd & mask, exp);
  endtask : rd_chk

  task automatic wait_stat(input logic [7:0] mask, input logic [7:0] val);
    int n;
    n = 0;
    do begin
      apb(1'b0, IDX_STATUS, 8'h00);
      n++;
    end while ((rd[7:0] & mask) !== val && n < 400);
    chk({24'h000000, rd[7:0] & mask}, {24'h000000, val});
  endtask : wait_stat

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #400000;
    errors++;
    give_verdict();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h00000000;
    drv_ss_n = 1'b1;
    drv_sclk = 1'b0;
    drv_mosi = 1'b1;
    slow = 1'b0;
    reply = 8'h00;
    log_rise = 1'b0;
    errors = 0;
    total_checks = 0;
    seed = 32'hF019;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(IDX_STATUS, 32'hFFFFFFFF, 32'h00000000);
    rd_chk(IDX_CONFIG, 32'hFFFFFFFF, 32'h00000001);
    apb(1'b0, 8'h10, 8'h00);
    chk({31'h0, err}, 32'h00000001);
    $display("test reset values done");
    apb(1'b1, IDX_IRQ_EN, 8'h1F);
    apb(1'b1, IDX_CONFIG, 8'h51);
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      b0 = seed[7:0];
      reply <= seed[15:8];
      slow <= i[0];
      n0 = peer_n;
      apb(1'b1, IDX_TXBUF, b0);
      wait_stat(8'h80, 8'h80);
      wait_stat(8'h80, 8'h00);
      chk({24'h000000, peer_got}, {24'h000000, b0});
      rd_chk(IDX_STATUS, 32'hFFFFFFFF, 32'h0000001E);
      chk({31'h0, ss_w}, 32'h00000001);
      chk({31'h0, irq}, 32'h00000001);
      apb(1'b1, IDX_IRQ_EN, 8'h00);
      rd_chk(IDX_IRQ_STAT, 32'h0000000B, 32'h0000000B);
      chk({31'h0, irq}, 32'h00000000);
      apb(1'b1, IDX_IRQ_EN, 8'h1F);
      apb(1'b1, IDX_IRQ_CLR, 8'h1F);
      rd_chk(IDX_IRQ_STAT, 32'hFFFFFFFF, 32'h00000000);
      chk({31'h0, irq}, 32'h00000000);
      rd_chk(IDX_RXBUF, 32'hFFFFFFFF, exp_rx(1'b0, reply, n0));
      rd_chk(IDX_STATUS, 32'hFFFFFFFF, 32'h00000006);
      apb(1'b1, IDX_STATUS, 8'h00);
      rd_chk(IDX_STATUS, 32'hFFFFFFFF, 32'h00000000);
      $display("test single byte %0d done", i);
    end
    for (int ov = 0; ov < 2; ov++) begin
      apb(1'b1, IDX_CONFIG, ov[0] ? 8'h71 : 8'h51);
      seed = lfsr(seed);
      b0 = seed[7:0];
      b1 = seed[15:8];
      reply <= seed[23:16];
      n0 = peer_n;
      apb(1'b1, IDX_TXBUF, b0);
      wait_stat(8'h03, 8'h02);
      apb(1'b1, IDX_TXBUF, b1);
      wait_stat(8'h80, 8'h00);
      chk({24'h000000, peer_got}, {24'h000000, b1});
      rd_chk(IDX_STATUS, 32'h00000038, 32'h00000038);
      rd_chk(IDX_RXBUF, 32'hFFFFFFFF, exp_rx(ov[0], reply, n0));
      rd_chk(IDX_STATUS, 32'h00000038, 32'h00000000);
      apb(1'b1, IDX_STATUS, 8'h00);
      $display("test overflow %0d done", ov);
    end
    // Mode bit at zero on purpose, to see the halt on an unread buffer
    apb(1'b1, IDX_CONFIG, 8'h50);
    seed = lfsr(seed);
    reply <= seed[7:0];
    n0 = peer_n;
    log_rise <= 1'b1;
    apb(1'b1, IDX_TXBUF, seed[15:8]);
    wait_stat(8'h01, 8'h00);
    apb(1'b1, IDX_TXBUF, seed[23:16]);
    wait_stat(8'h01, 8'h00);
    apb(1'b1, IDX_TXBUF, seed[31:24]);
    wait_stat(8'h80, 8'h00);
    chk(at_rise - n0, 32'h00000002);
    repeat (200) @(posedge pclk);
    wait_stat(8'h80, 8'h00);
    apb(1'b0, IDX_RXBUF, 8'h00);
    apb(1'b1, IDX_STATUS, 8'h00);
    rd_chk(IDX_STATUS, 32'h00000001, 32'h00000000);
    $display("test halt done");
    apb(1'b1, IDX_CONFIG, 8'hD1);
    seed = lfsr(seed);
    apb(1'b1, IDX_TXBUF, seed[7:0]);
    wait_stat(8'h80, 8'h80);
    drv_ss_n <= 1'b0;
    wait_stat(8'h40, 8'h40);
    drv_ss_n <= 1'b1;
    wait_stat(8'h80, 8'h00);
    apb(1'b0, IDX_STATUS, 8'h00);
    b0 = rd[7:0];
    apb(1'b1, IDX_STATUS, 8'hBF);
    rd_chk(IDX_STATUS, 32'hFFFFFFFF, {24'h000000, b0 & 8'hBF});
    $display("test multimaster done");
    // Slave receive: the bench plays master, mode 0, 80 ns link period, nothing queued to send
    apb(1'b1, IDX_CONFIG, 8'h41);
    seed = lfsr(seed);
    b1 = seed[7:0];
    drv_ss_n <= 1'b0;
    for (int k = 7; k >= 0; k--) begin
      drv_mosi <= b1[k];
      repeat (5) @(posedge pclk);
      drv_sclk <= 1'b1;
      repeat (5) @(posedge pclk);
      drv_sclk <= 1'b0;
    end
    repeat (5) @(posedge pclk);
    drv_ss_n <= 1'b1;
    wait_stat(8'h80, 8'h00);
    rd_chk(IDX_STATUS, 32'h0000001D, 32'h0000001C);
    rd_chk(IDX_RXBUF, 32'hFFFFFFFF, {24'h000000, b1});
    $display("test slave receive done");
    // Port disabled so a queued byte stays queued for the written-zero clear
    apb(1'b1, IDX_CONFIG, 8'h01);
    apb(1'b1, IDX_TXBUF, seed[15:8]);
    rd_chk(IDX_STATUS, 32'h00000003, 32'h00000001);
    apb(1'b1, IDX_STATUS, 8'hFE);
    rd_chk(IDX_STATUS, 32'h00000003, 32'h00000000);
    $display("test zero clear done");
    give_verdict();
  end
endmodule : testbench
